// file: core/apbc_cfg.svh
`ifndef APBC_CFG_SVH
`define APBC_CFG_SVH

// Result width and code limits
`define APBC_RESULT_BITS 10
`define APBC_CODE_ZERO 10'h000
`define APBC_CODE_FULL 10'h3FF

// Timing in nanoseconds at a 25 ns clock
`define APBC_CLK_PERIOD_NS 25
`define APBC_CONV_TIME_NS 6000
`define APBC_DONE_CLEAR_NS 50
// Longest times round down, never below one cycle
`define APBC_CONV_CYCLES ((`APBC_CONV_TIME_NS / `APBC_CLK_PERIOD_NS) < 1 ? 1 : \
    (`APBC_CONV_TIME_NS / `APBC_CLK_PERIOD_NS))
`define APBC_DONE_CLEAR_CYCLES ((`APBC_DONE_CLEAR_NS / `APBC_CLK_PERIOD_NS) < 1 ? 1 : \
    (`APBC_DONE_CLEAR_NS / `APBC_CLK_PERIOD_NS))

// Cycles without an external clock fall before the internal clock is used;
// longer than the slowest allowed external period, so a slow clock is not dropped
`define APBC_EXT_CLK_TIMEOUT 100
// External clock falling edges counted before the next one switches to the external clock
`define APBC_EXT_CLK_LOCK 4

`endif

// file: core/apbc_pkg.sv
package apbc_pkg;
    // Converter sequence, Gray coded along idle, hold, finish
    typedef enum logic [1:0] {
        APBC_SAMPLE = 2'b00,
        APBC_HOLD = 2'b01,
        APBC_LOAD = 2'b11
    } apbc_state_t;

    // Which converter clock drives the bit steps
    typedef enum logic {
        APBC_CLK_INTERNAL = 1'b0,
        APBC_CLK_EXTERNAL = 1'b1
    } apbc_clk_sel_t;
endpackage

// file: core/apbc_clk_select.sv
`include "apbc_cfg.svh"

// Chooses internal or external converter clock and emits step ticks
module apbc_clk_select #(
    parameter int TIMEOUT = `APBC_EXT_CLK_TIMEOUT,
    parameter int LOCK = `APBC_EXT_CLK_LOCK
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic external_clock_in,
    output apbc_pkg::apbc_clk_sel_t clk_sel,
    output logic step_tick
);
    import apbc_pkg::*;

    // Refuse counts that the counters cannot hold
    if (TIMEOUT < 2 || LOCK < 1 || LOCK > 255 || TIMEOUT > 65535) begin
        $error("apbc_clk_select: bad TIMEOUT or LOCK");
    end

    logic ext_prev_reg;
    logic ext_fall;
    logic [15:0] idle_cnt_reg;
    logic [7:0] lock_cnt_reg;
    apbc_clk_sel_t sel_reg;

    assign ext_fall = ext_prev_reg & ~external_clock_in;

    // Edge history of the external clock pin
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_prev_reg <= 1'b1;
        end else begin
            ext_prev_reg <= external_clock_in;
        end
    end

    // Held high or idle pin falls back to the internal clock
    always_ff @(posedge clk) begin
        if (reset || ext_fall) begin
            idle_cnt_reg <= 16'h0000;
        end else if (idle_cnt_reg != 16'(TIMEOUT)) begin
            idle_cnt_reg <= idle_cnt_reg + 16'h0001;
        end
    end

    // A few edges are needed before switching, as the pin may glitch
    always_ff @(posedge clk) begin
        if (reset) begin
            lock_cnt_reg <= 8'h00;
            sel_reg <= APBC_CLK_INTERNAL;
        end else if (idle_cnt_reg == 16'(TIMEOUT)) begin
            lock_cnt_reg <= 8'h00;
            sel_reg <= APBC_CLK_INTERNAL;
        end else if (ext_fall) begin
            if (lock_cnt_reg == 8'(LOCK)) begin
                sel_reg <= APBC_CLK_EXTERNAL;
            end else begin
                lock_cnt_reg <= lock_cnt_reg + 8'h01;
            end
        end
    end

    assign clk_sel = sel_reg;
    // Internal clock steps every cycle; external steps on its falling edge
    assign step_tick = (sel_reg == APBC_CLK_EXTERNAL) ? ext_fall : 1'b1;
endmodule

// file: core/apbc_sar.sv
`include "apbc_cfg.svh"

// Successive approximation against the held sample, one bit per step
module apbc_sar #(
    parameter int WIDTH = `APBC_RESULT_BITS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic step,
    input wire logic [WIDTH-1:0] held_sample,
    output logic [WIDTH-1:0] code,
    output logic done
);
    // Refuse widths the step logic is not sized for
    if (WIDTH < 2 || WIDTH > 16) begin
        $error("apbc_sar: WIDTH out of range");
    end

    logic [WIDTH-1:0] trial_reg;
    logic [WIDTH-1:0] mask_reg;
    logic busy_reg;
    logic [WIDTH-1:0] probe;

    assign probe = trial_reg | mask_reg;

    // Keep a bit when the probe does not exceed the sample
    always_ff @(posedge clk) begin
        if (reset) begin
            trial_reg <= '0;
            mask_reg <= '0;
            busy_reg <= 1'b0;
        end else if (start) begin
            trial_reg <= '0;
            mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
            busy_reg <= 1'b1;
        end else if (busy_reg && step) begin
            if (probe <= held_sample) begin
                trial_reg <= probe;
            end
            mask_reg <= mask_reg >> 1;
            if (mask_reg[0]) begin
                busy_reg <= 1'b0;
            end
        end
    end

    assign code = trial_reg;
    assign done = ~busy_reg;
endmodule

// file: core/apbc_bus_control.sv
// What this block does
// - Result bit 0 is LSB, bit 9 MSB
// - Done flag goes low as the latch loads
// - Select and read low drive latch out
// - Latch captures at done flag falling edge
// - Read falling edge raises done flag quickly
// - Select low, write rising edge starts conversion
// - Write rising edge stops sampling, holds input
// - Track input outside the conversion interval
// - Input at or above top gives ones
// - Input within span gives proportional code
// - Input at or below bottom gives zeros
// - Strobes ignored unless select is low
// - Internal clock unless external clock toggles
`include "apbc_cfg.svh"

module apbc_bus_control #(
    parameter int WIDTH = `APBC_RESULT_BITS,
    parameter int CONV_CYCLES = `APBC_CONV_CYCLES,
    parameter int CLEAR_CYCLES = `APBC_DONE_CLEAR_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic external_clock_in,
    input wire logic [WIDTH-1:0] analog_level,
    input wire logic [WIDTH-1:0] ref_low,
    input wire logic [WIDTH-1:0] ref_high,
    output logic [WIDTH-1:0] result_bus_out,
    output logic result_bus_oe,
    output logic conversion_done_n,
    output logic sampling,
    output apbc_pkg::apbc_clk_sel_t clk_sel
);
    import apbc_pkg::*;

    // Refuse a conversion too short for every bit step or too long for the counter
    if (CONV_CYCLES < WIDTH + 2 || CONV_CYCLES > 65535 || CLEAR_CYCLES < 1) begin
        $error("apbc_bus_control: conversion must cover all bit steps");
    end

    // Scale the analog level into the reference span; clamp outside it
    function automatic logic [WIDTH-1:0] scale_level(
        input logic [WIDTH-1:0] level,
        input logic [WIDTH-1:0] lo,
        input logic [WIDTH-1:0] hi
    );
        logic [2*WIDTH-1:0] num;
        logic [WIDTH-1:0] span;
        num = '0;
        span = hi - lo;
        if (level <= lo || hi <= lo) begin
            scale_level = '0;
        end else if (level >= hi) begin
            scale_level = '1;
        end else begin
            num = {{WIDTH{1'b0}}, level - lo} * {{WIDTH{1'b0}}, {WIDTH{1'b1}}};
            scale_level = WIDTH'(num / {{WIDTH{1'b0}}, span});
        end
    endfunction

    apbc_state_t state_reg;
    logic write_prev_reg;
    logic read_prev_reg;
    logic [WIDTH-1:0] sample_reg;
    logic [WIDTH-1:0] latch_reg;
    logic done_n_reg;
    logic [15:0] conv_cnt_reg;
    logic write_rise;
    logic read_fall;
    logic step_tick;
    logic sar_start;
    logic sar_done;
    logic [WIDTH-1:0] sar_code;

    // Strobe edges only count while selected
    assign write_rise = ~chip_select_n & write_n & ~write_prev_reg;
    assign read_fall = ~chip_select_n & ~read_n & read_prev_reg;
    assign sar_start = write_rise && state_reg == APBC_SAMPLE;

    // Strobe history; reset as idle high so no edge appears at release
    always_ff @(posedge clk) begin
        if (reset) begin
            write_prev_reg <= 1'b1;
            read_prev_reg <= 1'b1;
        end else begin
            write_prev_reg <= write_n;
            read_prev_reg <= read_n;
        end
    end

    apbc_clk_select u_clk_select (
        .clk(clk),
        .reset(reset),
        .external_clock_in(external_clock_in),
        .clk_sel(clk_sel),
        .step_tick(step_tick)
    );

    apbc_sar #(
        .WIDTH(WIDTH)
    ) u_sar (
        .clk(clk),
        .reset(reset),
        .start(sar_start),
        .step(step_tick),
        .held_sample(sample_reg),
        .code(sar_code),
        .done(sar_done)
    );

    // Conversion sequence; a write during conversion is ignored
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= APBC_SAMPLE;
            conv_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                APBC_SAMPLE: begin
                    if (sar_start) begin
                        state_reg <= APBC_HOLD;
                        conv_cnt_reg <= 16'h0000;
                    end
                end
                APBC_HOLD: begin
                    if (conv_cnt_reg != 16'hFFFF) begin
                        conv_cnt_reg <= conv_cnt_reg + 16'h0001;
                    end
                    // Minimum conversion time, and never before the last bit
                    if (conv_cnt_reg >= 16'(CONV_CYCLES - 2) && sar_done) begin
                        state_reg <= APBC_LOAD;
                    end
                end
                APBC_LOAD: begin
                    state_reg <= APBC_SAMPLE;
                end
                default: begin
                    state_reg <= APBC_SAMPLE;
                end
            endcase
        end
    end

    // Track input while sampling, freeze while holding
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_reg <= '0;
        end else if (state_reg == APBC_SAMPLE && !sar_start) begin
            sample_reg <= scale_level(analog_level, ref_low, ref_high);
        end
    end

    // Latch loads in the same step that pulls the flag low
    always_ff @(posedge clk) begin
        if (reset) begin
            latch_reg <= '0;
        end else if (state_reg == APBC_LOAD) begin
            latch_reg <= sar_code;
        end
    end

    // Load wins over a read edge in the same cycle, so no result is missed
    always_ff @(posedge clk) begin
        if (reset) begin
            done_n_reg <= 1'b1;
        end else if (state_reg == APBC_LOAD) begin
            done_n_reg <= 1'b0;
        end else if (read_fall) begin
            done_n_reg <= 1'b1;
        end
    end

    assign conversion_done_n = done_n_reg;
    assign sampling = state_reg != APBC_HOLD;
    // Latch bit order is result bit order: index 0 carries the LSB
    assign result_bus_out = latch_reg;
    // Drive only while selected and read low, else share the host bus
    assign result_bus_oe = ~chip_select_n & ~read_n;
endmodule

// file: sim/apbc_asserts.sv
module apbc_asserts import apbc_pkg::*; #(
    parameter int WIDTH = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic [WIDTH-1:0] analog_level,
    input wire logic [WIDTH-1:0] ref_low,
    input wire logic [WIDTH-1:0] ref_high,
    input wire logic [WIDTH-1:0] result_bus_out,
    input wire logic result_bus_oe,
    input wire logic conversion_done_n,
    input wire logic sampling
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Bus drive follows select and read only
    bus_drive_a: assert property (result_bus_oe == (!chip_select_n && !read_n))
        else $error("result bus drive wrong");
    done_clear_a: assert property ($fell(read_n) && !chip_select_n && !conversion_done_n
        |=> conversion_done_n) else $error("done flag not cleared");
    start_hold_a: assert property (!chip_select_n && $rose(write_n) && sampling
        |=> !sampling) else $error("no hold on start");
    conv_ends_a: assert property ($fell(sampling) |-> ##[1:300] $fell(conversion_done_n))
        else $error("conversion never done");
    latch_hold_a: assert property (!$fell(conversion_done_n) |-> $stable(result_bus_out))
        else $error("latch moved");
    resample_a: assert property ($fell(conversion_done_n) |-> sampling)
        else $error("not sampling after end");
    desel_wr_a: assert property (chip_select_n && $rose(write_n) && sampling |=> sampling)
        else $error("start seen unselected");
    desel_rd_a: assert property (chip_select_n && $fell(read_n) && !conversion_done_n
        |=> !conversion_done_n) else $error("read seen unselected");
    full_code_a: assert property ($fell(conversion_done_n) && analog_level >= ref_high
        |-> result_bus_out == '1) else $error("top code wrong");
    zero_code_a: assert property ($fell(conversion_done_n) && analog_level <= ref_low
        |-> result_bus_out == '0) else $error("bottom code wrong");
    cover property ($fell(conversion_done_n));
    cover property ($fell(read_n) && !chip_select_n && !conversion_done_n);
    cover property (chip_select_n && $rose(write_n));
endmodule

bind apbc_bus_control apbc_asserts #(.WIDTH(WIDTH)) u_chk (.clk(clk), .reset(reset),
    .chip_select_n(chip_select_n), .write_n(write_n), .read_n(read_n),
    .analog_level(analog_level), .ref_low(ref_low), .ref_high(ref_high),
    .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe),
    .conversion_done_n(conversion_done_n), .sampling(sampling));

// file: sim/apbc_host_model.sv
module apbc_host_model (
    input wire logic clk,
    input wire logic want_sel,
    input wire logic want_wr,
    input wire logic want_rd,
    input wire logic ext_run,
    output logic chip_select_n = 1'b1,
    output logic write_n = 1'b1,
    output logic read_n = 1'b1,
    output logic external_clock_in = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_reg = 2'h0;
    // Strobes move just after the edge; caller keeps select around them
    always_ff @(posedge clk) begin
        chip_select_n <= ~want_sel;
        write_n <= ~want_wr;
        read_n <= ~want_rd;
    end
    // 5 MHz converter clock on request, else held high for the internal one
    always_ff @(posedge clk) begin
        div_reg <= div_reg + 2'h1;
        if (!ext_run) begin
            external_clock_in <= 1'b1;
        end else if (div_reg == 2'h3) begin
            external_clock_in <= ~external_clock_in;
        end
    end
endmodule

// file: sim/apbc_bus_control_test.sv
module apbc_bus_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import apbc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic want_sel = 1'b0;
    logic want_wr = 1'b0;
    logic want_rd = 1'b0;
    logic ext_run = 1'b0;
    logic cs_n, wr_n, rd_n, ext_clk, oe, done_n, sampling;
    logic [9:0] level = 10'h000;
    logic [9:0] lo = 10'h000;
    logic [9:0] hi = 10'h3FF;
    logic [9:0] data;
    apbc_clk_sel_t clk_sel;
    int err_total = 0;
    int compares = 0;
    // Short conversion keeps the run brief
    apbc_bus_control #(.CONV_CYCLES(12)) u_dut (.clk(clk), .reset(reset),
        .chip_select_n(cs_n), .write_n(wr_n), .read_n(rd_n), .external_clock_in(ext_clk),
        .analog_level(level), .ref_low(lo), .ref_high(hi), .result_bus_out(data),
        .result_bus_oe(oe), .conversion_done_n(done_n), .sampling(sampling), .clk_sel(clk_sel));
    apbc_host_model u_host (.clk(clk), .want_sel(want_sel), .want_wr(want_wr),
        .want_rd(want_rd), .ext_run(ext_run), .chip_select_n(cs_n), .write_n(wr_n),
        .read_n(rd_n), .external_clock_in(ext_clk));
    always #12.5 clk = ~clk;
    task automatic give_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Codes near a rounding step may land one off
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input int tol);
        compares++;
        if ($isunknown(got) || (got > exp ? got - exp : exp - got) > tol) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic read_check(input logic [9:0] exp, input int tol);
        want_sel = 1'b1;
        tick(1);
        want_rd = 1'b1;
        tick(1);
        chk(10'(oe), 10'h001, 0);
        chk(data, exp, tol);
        tick(1);
        chk(10'(done_n), 10'h001, 0);
        want_rd = 1'b0;
        tick(1);
        want_sel = 1'b0;
        tick(1);
        chk(10'(oe), 10'h000, 0);
    endtask
    task automatic convert(input logic [9:0] lvl, input logic [9:0] exp, input int tol);
        int n;
        n = 0;
        level = lvl;
        want_sel = 1'b1;
        tick(1);
        want_wr = 1'b1;
        tick(2);
        want_wr = 0;
        tick(2);
        chk(10'(sampling), 10'h000, 0);
        while (done_n !== 1'b0 && n < 3000) begin
            tick(1);
            n++;
        end
        chk(10'(done_n), 10'h000, 0);
        chk(10'(sampling), 10'h001, 0);
        // Unselected read must neither drive the bus nor clear the flag
        want_sel = 1'b0;
        tick(1);
        want_rd = 1'b1;
        tick(2);
        chk(10'(oe), 10'h000, 0);
        want_rd = 1'b0;
        tick(1);
        chk(10'(done_n), 10'h000, 0);
        read_check(exp, tol);
        level = ~lvl;
        read_check(exp, tol);
    endtask
    task automatic unselected();
        want_wr = 1'b1;
        tick(2);
        want_wr = 1'b0;
        tick(20);
        chk(10'(sampling), 10'h001, 0);
        chk(10'(done_n), 10'h001, 0);
    endtask
    // Watchdog
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    initial begin
        tick(4);
        reset = 1'b0;
        tick(1);
        unselected();
        convert(10'h3FF, 10'h3FF, 0);
        convert(10'h000, 10'h000, 0);
        convert(10'h155, 10'h155, 1);
        lo = 10'h100;
        hi = 10'h300;
        convert(10'h380, 10'h3FF, 0);
        convert(10'h080, 10'h000, 0);
        convert(10'h200, 10'h1FF, 1);
        ext_run = 1'b1;
        tick(80);
        chk(10'(clk_sel), 10'(APBC_CLK_EXTERNAL), 0);
        convert(10'h200, 10'h1FF, 1);
        ext_run = 1'b0;
        tick(120);
        chk(10'(clk_sel), 10'(APBC_CLK_INTERNAL), 0);
        give_verdict();
    end
endmodule
